// [design/dsa_arith.sv]
/*
 * Saturating DSP arithmetic datapath: dual halfword and full word signed multiply and subtract,
 * each clipped to its signed range and guarded by an optional predicate.
 * Assumes issue logic presents one operation per cycle with operands already read from the
 * register file, and that the register file writes a result only when its write strobe is high.
 */
// How it works
// - The dual multiply forms upper-by-upper and lower-by-lower signed products, each clipped to 16 bits.
// - With a guard present, the write strobe is raised only when guard bit 0 is 1, else nothing is written.
// - The guard is optional for every operation and an unguarded operation always writes.
// - The dual subtract sign-extends each lane and subtracts the second source lane from the first.
// - A lane difference below 0xffff8000 becomes 0x8000, above 0x7fff becomes 0x7fff, else passes.
// - Dual results put the upper lane in bits 31:16 and the lower lane in bits 15:0.
// - The word multiply forms the full 64-bit product and clips it to the signed 32-bit range.
// - The word subtract forms a 64-bit difference and clips values below the minimum to 0x80000000.
// - A word difference above the maximum gives 0x7fffffff and in-range differences pass unchanged.
`timescale 1ns/100ps
`include "dsa_defs.svh"

module dsa_arith #(
	parameter int DEST_W = 7
) (
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire logic                  issue_valid,
	input  wire dsa_pkg::dsa_op_t      issue_op,
	input  wire logic [31:0]           first_source,
	input  wire logic [31:0]           second_source,
	input  wire logic                  guard_present,
	input  wire logic [31:0]           guard_value,
	input  wire logic [DEST_W-1:0]     issue_dest,
	output logic                       alu_valid_r,
	output logic                       alu_write_r,
	output logic [31:0]                alu_data_r,
	output logic [DEST_W-1:0]          alu_dest_r,
	output logic                       mul_valid_r,
	output logic                       mul_write_r,
	output logic [31:0]                mul_data_r,
	output logic [DEST_W-1:0]          mul_dest_r
);

	// ------------------------------------------------------------------------
	// Issue decode
	// ------------------------------------------------------------------------
	function automatic logic signed [31:0] lane_ext(input logic [31:0] word, input logic hi);
		logic [15:0] lane;
		lane = hi ? word[`DSA_HI_LSB +: `DSA_LANE_W] : word[`DSA_LO_LSB +: `DSA_LANE_W];
		return {{16{lane[15]}}, lane};
	endfunction

	logic issue_we;
	logic issue_sub;
	logic issue_mul;

	assign issue_we  = !guard_present || guard_value[`DSA_GUARD_BIT];
	assign issue_sub = issue_valid && (issue_op == dsa_pkg::DSA_OP_DUAL_SUB || issue_op == dsa_pkg::DSA_OP_WORD_SUB);
	assign issue_mul = issue_valid && (issue_op == dsa_pkg::DSA_OP_DUAL_MUL || issue_op == dsa_pkg::DSA_OP_WORD_MUL);

	// ------------------------------------------------------------------------
	// Subtract path, two stages
	// ------------------------------------------------------------------------
	logic              sub_v_r;
	logic              sub_we_r;
	logic              sub_dual_r;
	logic [31:0]       sub_a_r;
	logic [31:0]       sub_b_r;
	logic [DEST_W-1:0] sub_dest_r;
	logic [15:0]       sub_lane[2];
	logic signed [63:0] sub_wdiff;
	logic [31:0]       sub_word;

	always_ff @(posedge clock) begin
		if (rst) begin
			sub_v_r    <= 1'b0;
			sub_we_r   <= 1'b0;
			sub_dual_r <= 1'b0;
			sub_a_r    <= `DSA_DATA_RST;
			sub_b_r    <= `DSA_DATA_RST;
			sub_dest_r <= '0;
		end else begin
			sub_v_r    <= issue_sub;
			sub_we_r   <= issue_we;
			sub_dual_r <= issue_op == dsa_pkg::DSA_OP_DUAL_SUB;
			sub_a_r    <= first_source;
			sub_b_r    <= second_source;
			sub_dest_r <= issue_dest;
		end
	end

	for (genvar i = 0; i < 2; i++) begin : g_sub_lane
		logic signed [31:0] diff;
		assign diff = lane_ext(sub_a_r, i == 1) - lane_ext(sub_b_r, i == 1);
		dsa_clip #(.IN_W(32), .OUT_W(16)) u_clip (
			.value   (diff),
			.clipped (sub_lane[i])
		);
	end

	assign sub_wdiff = $signed({{32{sub_a_r[31]}}, sub_a_r}) - $signed({{32{sub_b_r[31]}}, sub_b_r});

	dsa_clip #(.IN_W(64), .OUT_W(32)) u_sub_word (
		.value   (sub_wdiff),
		.clipped (sub_word)
	);

	always_ff @(posedge clock) begin
		if (rst) begin
			alu_valid_r <= 1'b0;
			alu_write_r <= 1'b0;
			alu_data_r  <= `DSA_DATA_RST;
			alu_dest_r  <= '0;
		end else begin
			alu_valid_r <= sub_v_r;
			alu_write_r <= sub_v_r && sub_we_r;
			alu_data_r  <= sub_dual_r ? {sub_lane[1], sub_lane[0]} : sub_word;
			alu_dest_r  <= sub_dest_r;
		end
	end

	// ------------------------------------------------------------------------
	// Multiply path, three stages
	// ------------------------------------------------------------------------
	logic               m1_v_r;
	logic               m1_we_r;
	logic               m1_dual_r;
	logic [31:0]        m1_a_r;
	logic [31:0]        m1_b_r;
	logic [DEST_W-1:0]  m1_dest_r;
	logic               m2_v_r;
	logic               m2_we_r;
	logic               m2_dual_r;
	logic [DEST_W-1:0]  m2_dest_r;
	logic signed [63:0] m2_word_r;
	logic signed [31:0] m2_lane_r[2];
	logic [15:0]        mul_lane[2];
	logic [31:0]        mul_word;

	always_ff @(posedge clock) begin
		if (rst) begin
			m1_v_r    <= 1'b0;
			m1_we_r   <= 1'b0;
			m1_dual_r <= 1'b0;
			m1_a_r    <= `DSA_DATA_RST;
			m1_b_r    <= `DSA_DATA_RST;
			m1_dest_r <= '0;
		end else begin
			m1_v_r    <= issue_mul;
			m1_we_r   <= issue_we;
			m1_dual_r <= issue_op == dsa_pkg::DSA_OP_DUAL_MUL;
			m1_a_r    <= first_source;
			m1_b_r    <= second_source;
			m1_dest_r <= issue_dest;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			m2_v_r       <= 1'b0;
			m2_we_r      <= 1'b0;
			m2_dual_r    <= 1'b0;
			m2_dest_r    <= '0;
			m2_word_r    <= '0;
			m2_lane_r[0] <= '0;
			m2_lane_r[1] <= '0;
		end else begin
			m2_v_r       <= m1_v_r;
			m2_we_r      <= m1_we_r;
			m2_dual_r    <= m1_dual_r;
			m2_dest_r    <= m1_dest_r;
			m2_word_r    <= $signed({{32{m1_a_r[31]}}, m1_a_r}) * $signed({{32{m1_b_r[31]}}, m1_b_r});
			m2_lane_r[0] <= lane_ext(m1_a_r, 1'b0) * lane_ext(m1_b_r, 1'b0);
			m2_lane_r[1] <= lane_ext(m1_a_r, 1'b1) * lane_ext(m1_b_r, 1'b1);
		end
	end

	for (genvar i = 0; i < 2; i++) begin : g_mul_lane
		dsa_clip #(.IN_W(32), .OUT_W(16)) u_clip (
			.value   (m2_lane_r[i]),
			.clipped (mul_lane[i])
		);
	end

	dsa_clip #(.IN_W(64), .OUT_W(32)) u_mul_word (
		.value   (m2_word_r),
		.clipped (mul_word)
	);

	always_ff @(posedge clock) begin
		if (rst) begin
			mul_valid_r <= 1'b0;
			mul_write_r <= 1'b0;
			mul_data_r  <= `DSA_DATA_RST;
			mul_dest_r  <= '0;
		end else begin
			mul_valid_r <= m2_v_r;
			mul_write_r <= m2_v_r && m2_we_r;
			mul_data_r  <= m2_dual_r ? {mul_lane[1], mul_lane[0]} : mul_word;
			mul_dest_r  <= m2_dest_r;
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	logic signed [63:0] chk_wsub;
	logic signed [63:0] chk_wmul;
	logic signed [31:0] chk_hsub;
	logic signed [31:0] chk_lmul;
	logic        [31:0] chk_wsub_lo;

	assign chk_wsub = $signed({{32{first_source[31]}}, first_source}) - $signed({{32{second_source[31]}}, second_source});
	assign chk_wmul = $signed({{32{first_source[31]}}, first_source}) * $signed({{32{second_source[31]}}, second_source});
	assign chk_hsub = lane_ext(first_source, 1'b1) - lane_ext(second_source, 1'b1);
	assign chk_lmul = lane_ext(first_source, 1'b0) * lane_ext(second_source, 1'b0);
	assign chk_wsub_lo = chk_wsub[31:0];

	a_sub_latency: assert property (@(posedge clock) disable iff (rst)
		issue_sub |-> ##2 (alu_valid_r && alu_dest_r == $past(issue_dest, 2)))
		else $error("subtract result not delivered two cycles after issue");

	a_mul_latency: assert property (@(posedge clock) disable iff (rst)
		issue_mul |-> ##3 (mul_valid_r && mul_dest_r == $past(issue_dest, 3)))
		else $error("multiply result not delivered three cycles after issue");

	a_guard_blocks_write: assert property (@(posedge clock) disable iff (rst)
		(issue_sub && guard_present && !guard_value[0]) |-> ##2 !alu_write_r)
		else $error("guarded subtract wrote with a false guard");

	a_unguarded_writes: assert property (@(posedge clock) disable iff (rst)
		(issue_mul && (!guard_present || guard_value[0])) |-> ##3 mul_write_r)
		else $error("multiply with no guard or a true guard did not write");

	a_word_sub_low: assert property (@(posedge clock) disable iff (rst)
		(issue_valid && issue_op == dsa_pkg::DSA_OP_WORD_SUB && chk_wsub < -64'sd2147483648)
		|-> ##2 alu_data_r == `DSA_WORD_MIN)
		else $error("word subtract below minimum not clipped");

	a_word_sub_pass: assert property (@(posedge clock) disable iff (rst)
		(issue_valid && issue_op == dsa_pkg::DSA_OP_WORD_SUB && chk_wsub <= 64'sd2147483647
		&& chk_wsub >= -64'sd2147483648) |-> ##2 alu_data_r == $past(chk_wsub_lo, 2))
		else $error("in-range word difference altered");

	a_word_mul_high: assert property (@(posedge clock) disable iff (rst)
		(issue_valid && issue_op == dsa_pkg::DSA_OP_WORD_MUL && chk_wmul > 64'sd2147483647)
		|-> ##3 mul_data_r == `DSA_WORD_MAX)
		else $error("word product above maximum not clipped");

	a_dual_sub_hi: assert property (@(posedge clock) disable iff (rst)
		(issue_valid && issue_op == dsa_pkg::DSA_OP_DUAL_SUB && chk_hsub > 32'sd32767)
		|-> ##2 alu_data_r[31:16] == `DSA_HALF_MAX)
		else $error("upper lane difference above maximum not clipped");

	a_dual_mul_lo: assert property (@(posedge clock) disable iff (rst)
		(issue_valid && issue_op == dsa_pkg::DSA_OP_DUAL_MUL && chk_lmul < -32'sd32768)
		|-> ##3 mul_data_r[15:0] == `DSA_HALF_MIN)
		else $error("lower lane product below minimum not clipped");

endmodule

// [design/dsa_defs.svh]
/*
 * Constants of the saturating DSP arithmetic datapath: latencies, lane layout and clip limits.
 * Assumes it is included by bare name from every file that needs it.
 */
`ifndef DSA_DEFS_SVH
`define DSA_DEFS_SVH

// ----------------------------------------------------------------------------
// Latencies in clock cycles from issue to result
// ----------------------------------------------------------------------------
`define DSA_LAT_SUB   2
`define DSA_LAT_MUL   3

// ----------------------------------------------------------------------------
// Lane layout of a dual halfword word and position of the guard bit
// ----------------------------------------------------------------------------
`define DSA_LANE_W    16
`define DSA_HI_LSB    16
`define DSA_LO_LSB    0
`define DSA_GUARD_BIT 0

// ----------------------------------------------------------------------------
// Clip limits and reset value of result data
// ----------------------------------------------------------------------------
`define DSA_HALF_MAX  16'h7FFF
`define DSA_HALF_MIN  16'h8000
`define DSA_WORD_MAX  32'h7FFFFFFF
`define DSA_WORD_MIN  32'h80000000
`define DSA_DATA_RST  32'h00000000

`endif

// [design/dsa_pkg.sv]
/*
 * Types of the saturating DSP arithmetic datapath.
 * Assumes nothing of its surroundings.
 */
package dsa_pkg;

	typedef enum logic [1:0] {
		DSA_OP_DUAL_MUL,
		DSA_OP_DUAL_SUB,
		DSA_OP_WORD_MUL,
		DSA_OP_WORD_SUB
	} dsa_op_t;

endpackage

// [design/dsa_clip.sv]
/*
 * Combinational clip of a signed value into the signed range of a narrower field.
 * Assumes IN_W is larger than OUT_W and that the value is signed.
 */
`timescale 1ns/100ps

module dsa_clip #(
	parameter int IN_W  = 32,
	parameter int OUT_W = 16
) (
	input  wire logic signed [IN_W-1:0]  value,
	output logic             [OUT_W-1:0] clipped
);

	localparam logic signed [IN_W-1:0] MAX_V = {{(IN_W-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}};
	localparam logic signed [IN_W-1:0] MIN_V = {{(IN_W-OUT_W+1){1'b1}}, {(OUT_W-1){1'b0}}};

	// Values below the minimum give the most negative code, above the maximum the most positive.
	always_comb begin
		if (value < MIN_V) begin
			clipped = {1'b1, {(OUT_W-1){1'b0}}};
		end else if (value > MAX_V) begin
			clipped = {1'b0, {(OUT_W-1){1'b1}}};
		end else begin
			clipped = value[OUT_W-1:0];
		end
	end

endmodule

// [testbench/dsa_regfile_model.sv]
/*
 * Register file partner model: takes results from both result ports and offers one read port.
 * Assumes the datapath raises a write strobe only for results that may change their destination.
 */
`timescale 1ns/100ps

module dsa_regfile_model #(
	parameter int DEST_W = 7
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              alu_write_r,
	input  wire logic [31:0]       alu_data_r,
	input  wire logic [DEST_W-1:0] alu_dest_r,
	input  wire logic              mul_write_r,
	input  wire logic [31:0]       mul_data_r,
	input  wire logic [DEST_W-1:0] mul_dest_r,
	input  wire logic [DEST_W-1:0] rd_addr,
	output logic      [31:0]       rd_data
);
	logic [31:0] regs_r [2**DEST_W];

	// A register keeps its value unless a write strobe names it; the multiply port wins a clash.
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < 2**DEST_W; i++) begin
				regs_r[i] <= 32'h00000000;
			end
		end else begin
			if (alu_write_r) begin
				regs_r[alu_dest_r] <= alu_data_r;
			end
			if (mul_write_r) begin
				regs_r[mul_dest_r] <= mul_data_r;
			end
		end
	end

	assign rd_data = regs_r[rd_addr];
endmodule

// [testbench/tb_saturating_dsp_arith.sv]
/*
 * Self-checking bench of the saturating datapath: corner operands, guard cases and random traffic.
 * Assumes inputs change at the falling edge and results appear at the fixed latencies.
 */
`timescale 1ns/100ps
`include "dsa_defs.svh"

module tb_saturating_dsp_arith;
	localparam int DW = 7;
	localparam logic [1:0]  C_OP [13] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3};
	localparam logic [31:0] C_A [13] = '{32'h00020010, 32'h80000002, 32'h08000003, 32'h12340032, 32'h80000001,
		32'h00018001, 32'h00000010, 32'h40000000, 32'hFFFFFFFF, 32'h80000000, 32'h00001200, 32'h7FFFFFFF, 32'h80000000};
	localparam logic [31:0] C_B [13] = '{32'h00030020, 32'h00024000, 32'h00108001, 32'h00010002, 32'h00018001,
		32'h80010002, 32'h00000020, 32'h00000002, 32'hFFFFFFFF, 32'h00000002, 32'h000000FF, 32'hFFFFFFFF, 32'h00000001};
	logic             clock, rst, issue_valid, guard_present;
	logic             alu_valid_r, alu_write_r, mul_valid_r, mul_write_r;
	dsa_pkg::dsa_op_t issue_op;
	logic [31:0]      first_source, second_source, guard_value, alu_data_r, mul_data_r, rd_data, r;
	logic [DW-1:0]    issue_dest, alu_dest_r, mul_dest_r, rd_addr;
	logic             e_v [2][8];
	logic             e_w [2][8];
	logic [31:0]      e_d [2][8];
	logic [DW-1:0]    e_n [2][8];
	logic [31:0]      exp_rf [2**DW];
	int               n_errors = 0, samples_checked = 0, cyc = 0, seed = 88694;

	dsa_arith #(.DEST_W(DW)) u_dsa_arith (.clock(clock), .rst(rst), .issue_valid(issue_valid),
		.issue_op(issue_op), .first_source(first_source), .second_source(second_source),
		.guard_present(guard_present), .guard_value(guard_value), .issue_dest(issue_dest),
		.alu_valid_r(alu_valid_r), .alu_write_r(alu_write_r), .alu_data_r(alu_data_r), .alu_dest_r(alu_dest_r),
		.mul_valid_r(mul_valid_r), .mul_write_r(mul_write_r), .mul_data_r(mul_data_r), .mul_dest_r(mul_dest_r));
	dsa_regfile_model #(.DEST_W(DW)) u_dsa_regfile_model (.clock(clock), .rst(rst), .alu_write_r(alu_write_r),
		.alu_data_r(alu_data_r), .alu_dest_r(alu_dest_r), .mul_write_r(mul_write_r), .mul_data_r(mul_data_r),
		.mul_dest_r(mul_dest_r), .rd_addr(rd_addr), .rd_data(rd_data));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) cyc <= cyc + 1;

	// ----------------------------------------------------------------------------
	// Expected values
	// ----------------------------------------------------------------------------
	function automatic logic [31:0] clip(longint t, int w);
		longint mx;
		mx = (longint'(64'h1) << (w - 1)) - 1;
		if (t > mx) t = mx;
		else if (t < -mx - 1) t = -mx - 1;
		return t[31:0];
	endfunction

	function automatic logic [31:0] calc(dsa_pkg::dsa_op_t op, logic [31:0] a, logic [31:0] b);
		longint      x, y;
		logic [31:0] t, res;
		if (op == dsa_pkg::DSA_OP_WORD_MUL || op == dsa_pkg::DSA_OP_WORD_SUB) begin
			x = longint'($signed(a));
			y = longint'($signed(b));
			return clip(op == dsa_pkg::DSA_OP_WORD_MUL ? x * y : x - y, 32);
		end
		for (int i = 0; i < 2; i++) begin
			x = longint'($signed(a[16*i +: 16]));
			y = longint'($signed(b[16*i +: 16]));
			t = clip(op == dsa_pkg::DSA_OP_DUAL_MUL ? x * y : x - y, 16);
			res[16*i +: 16] = t[15:0];
		end
		return res;
	endfunction

	// ----------------------------------------------------------------------------
	// Comparison, issue and verdict
	// ----------------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		samples_checked++;
		if (got !== ex) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
			n_errors++;
		end
	endtask

	task automatic step(input logic v, input dsa_pkg::dsa_op_t op, input logic [31:0] a, input logic [31:0] b,
		input logic gp, input logic [31:0] gv, input logic [DW-1:0] d);
		int s, p;
		@(negedge clock);
		s = cyc % 8;
		chk("alu_valid_r", {31'h0, e_v[0][s]}, {31'h0, alu_valid_r});
		chk("mul_valid_r", {31'h0, e_v[1][s]}, {31'h0, mul_valid_r});
		chk("alu_write_r", {31'h0, e_v[0][s] && e_w[0][s]}, {31'h0, alu_write_r});
		chk("mul_write_r", {31'h0, e_v[1][s] && e_w[1][s]}, {31'h0, mul_write_r});
		if (e_v[0][s]) begin
			chk("alu_data_r", e_d[0][s], alu_data_r);
			chk("alu_dest_r", 32'(e_n[0][s]), 32'(alu_dest_r));
			if (e_w[0][s]) exp_rf[e_n[0][s]] = e_d[0][s];
		end
		if (e_v[1][s]) begin
			chk("mul_data_r", e_d[1][s], mul_data_r);
			chk("mul_dest_r", 32'(e_n[1][s]), 32'(mul_dest_r));
			if (e_w[1][s]) exp_rf[e_n[1][s]] = e_d[1][s];
		end
		e_v[0][s] = 1'b0;
		e_v[1][s] = 1'b0;
		issue_valid = v;
		issue_op = op;
		first_source = a;
		second_source = b;
		guard_present = gp;
		guard_value = gv;
		issue_dest = d;
		p = (op == dsa_pkg::DSA_OP_DUAL_MUL || op == dsa_pkg::DSA_OP_WORD_MUL) ? 1 : 0;
		s = (cyc + (p == 1 ? `DSA_LAT_MUL : `DSA_LAT_SUB)) % 8;
		if (v) begin
			e_v[p][s] = 1'b1;
			e_w[p][s] = !gp || gv[`DSA_GUARD_BIT];
			e_d[p][s] = calc(op, a, b);
			e_n[p][s] = d;
		end
	endtask

	task automatic give_verdict();
		if (n_errors == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------------
	initial begin
		rst = 1'b1;
		issue_valid = 1'b0;
		issue_op = dsa_pkg::DSA_OP_DUAL_MUL;
		first_source = 32'h00000000;
		second_source = 32'h00000000;
		guard_present = 1'b0;
		guard_value = 32'h00000000;
		issue_dest = '0;
		rd_addr = '0;
		for (int i = 0; i < 8; i++) begin
			e_v[0][i] = 1'b0;
			e_v[1][i] = 1'b0;
		end
		for (int i = 0; i < 2**DW; i++) exp_rf[i] = 32'h00000000;
		repeat (10) @(negedge clock);
		rst = 1'b0;
		for (int g = 0; g < 3; g++) begin
			for (int k = 0; k < 13; k++) begin
				step(1'b1, dsa_pkg::dsa_op_t'(C_OP[k]), C_A[k], C_B[k], g != 0,
					g == 2 ? 32'h00000001 : 32'hFFFFFFFE, DW'(k + 13 * g));
			end
		end
		repeat (400) begin
			r = $random(seed);
			step(r[0] | r[1], dsa_pkg::dsa_op_t'(r[3:2]), $random(seed), $random(seed), r[4], $random(seed),
				DW'(r[15:8]));
		end
		repeat (4) step(1'b0, dsa_pkg::DSA_OP_WORD_SUB, 32'h0, 32'h0, 1'b0, 32'h0, '0);
		for (int i = 0; i < 2**DW; i++) begin
			rd_addr = DW'(i);
			#1;
			chk("register file", exp_rf[i], rd_data);
		end
		give_verdict();
	end
endmodule
